// file: logic/fcs_flash_cmd.sv
// Purpose: Command launch, status flags and block protection of the flash.
// Assumes: Array engine on ref_clk; stop and debug inputs are synchronous.
// Notes: Byte registers on a plain strobe port, read data one cycle later.
// Behaviour
// - Protection loaded from nonvolatile copy; always readable.
// - Protection enabled: only smaller select values accepted.
// - Protection disabled: writes leave protection unchanged.
// - Select field bounds unprotected region; top protected.
// - Disable bit clear blocks program/erase of block.
// - Writing one to buffer-empty launches; flag clears.
// - Only a burst program may wait in the buffer behind a running burst.
// - Complete flag tracks idle; clears on launch.
// - Protected program/erase ignored; violation flag, write-one clear.
// - Sequence, divider or stop errors set access error.
// - Blank flag set by passing check; cleared by launch.
// - Decode blank check, byte and burst program.
// - Decode page erase and mass erase.
// - Any other code raises access error.
// - Debug mode may rewrite protection freely.
// - Passing blank check unsecures the device.

`timescale 1ns/1ns

module fcs_flash_cmd (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire fcs_pkg::fcs_bus_req_t bus_req,
	output logic [7:0] rd_data,
	input wire logic [7:0] nonvolatile_protection_copy,
	input wire logic [1:0] nonvolatile_security,
	input wire logic debug_active,
	input wire logic stop_entry,
	input wire logic arr_wr,
	input wire logic [15:0] arr_addr,
	input wire logic [7:0] arr_wdata,
	output logic op_start,
	output fcs_pkg::fcs_op_t op,
	output logic op_abort,
	input wire logic op_done,
	input wire logic op_blank,
	output logic [7:0] flash_clock_divider,
	output logic [1:0] security_code,
	output logic irq
);

	// ==========================================================
	// Declarations.
	// ==========================================================
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_DATA,
		SEQ_CMD
	} fcs_seq_t;

	localparam int IRQ_W_L = fcs_pkg::IRQ_W;

	fcs_seq_t seq_reg; // Progress of the three-step command sequence.
	logic load_reg; // High for the first cycle after reset release.
	logic [7:0] prot_reg; // Protection register.
	logic cbe_reg; // Command buffer empty flag.
	logic cc_reg; // Command complete flag.
	logic blank_reg; // Array verified blank flag.
	logic div_set_reg; // Divider has been written since reset.
	logic [7:0] div_reg; // Clock divider value for the engine.
	logic [15:0] lat_addr_reg; // Latched array address.
	logic [7:0] lat_data_reg; // Latched array data.
	logic [7:0] lat_cmd_reg; // Latched command code.
	logic pend_reg; // Launched command waits for the engine.
	fcs_pkg::fcs_op_t pend_op_reg; // The waiting command.
	logic run_reg; // Engine is executing a command.
	logic [7:0] run_cmd_reg; // Code of the running command.
	logic [1:0] sec_reg; // Security state code.
	logic [IRQ_W_L-1:0] irq_mask_reg; // Interrupt mask.
	logic cc_prev_reg; // Complete flag one cycle ago, for edge detect.
	logic [1:0] err_flags; // Violation and access error flags.
	logic [IRQ_W_L-1:0] irq_flags; // Sticky interrupt status.

	// Decoded register strokes.
	logic wr_prot, wr_stat, wr_cmd, wr_div, wr_irqs, wr_mask;
	logic launch; // Software writes one to the buffer-empty bit.
	logic legal; // Latched code is one of the five commands.
	logic is_burst; // Latched code is burst program.
	logic is_modify; // Latched code programs or erases.
	logic prot_hit; // Latched command touches a protected location.
	logic busy; // A command is running or waiting.
	logic seq_err; // Sequence broken this cycle.
	logic launch_err; // Launch refused as access error.
	logic launch_ok; // Launch accepted into the buffer.
	logic stop_err; // Stop entered while a command was in progress.
	logic transfer; // Waiting command moves to the engine.
	logic [15:0] unprot_end; // Last unprotected array address.
	logic [7:0] stat_byte; // Status register image.

	assign wr_prot = bus_req.wr && (bus_req.addr == fcs_pkg::OFS_PROTECTION);
	assign wr_stat = bus_req.wr && (bus_req.addr == fcs_pkg::OFS_STATUS);
	assign wr_cmd = bus_req.wr && (bus_req.addr == fcs_pkg::OFS_COMMAND);
	assign wr_div = bus_req.wr && (bus_req.addr == fcs_pkg::OFS_DIVIDER);
	assign wr_irqs = bus_req.wr && (bus_req.addr == fcs_pkg::OFS_IRQ_STATUS);
	assign wr_mask = bus_req.wr && (bus_req.addr == fcs_pkg::OFS_IRQ_MASK);
	assign launch = wr_stat && bus_req.wdata[fcs_pkg::ST_BUFFER_EMPTY];

	// ==========================================================
	// Command decode and protection check.
	// ==========================================================
	// Decode the latched code against the five recognised commands.
	always_comb begin
		legal = 1'b0;
		is_burst = 1'b0;
		is_modify = 1'b0;
		unique case (lat_cmd_reg)
			fcs_pkg::CMD_BLANK_CHECK: begin
				legal = 1'b1;
			end
			fcs_pkg::CMD_BYTE_PROGRAM: begin
				legal = 1'b1;
				is_modify = 1'b1;
			end
			fcs_pkg::CMD_BURST_PROGRAM: begin
				legal = 1'b1;
				is_modify = 1'b1;
				is_burst = 1'b1;
			end
			fcs_pkg::CMD_PAGE_ERASE, fcs_pkg::CMD_MASS_ERASE: begin
				legal = 1'b1;
				is_modify = 1'b1;
			end
			default: begin
				// Every other code is illegal.
				legal = 1'b0;
			end
		endcase
	end

	// The select field gives the top of the unprotected area in whole
	// pages; everything above it up to the array end is protected.
	assign unprot_end = {prot_reg[7:1], {fcs_pkg::PAGE_BITS{1'b1}}};

	// Mass erase always reaches the protected block while it is enabled.
	always_comb begin
		prot_hit = 1'b0;
		if (!prot_reg[fcs_pkg::PROT_DISABLE_BIT] && is_modify) begin
			if (lat_cmd_reg == fcs_pkg::CMD_MASS_ERASE) begin
				prot_hit = 1'b1;
			end else begin
				prot_hit = (lat_addr_reg > unprot_end);
			end
		end
	end

	// ==========================================================
	// Launch qualification.
	// ==========================================================
	assign busy = run_reg || pend_reg;
	// A stroke out of order breaks the sequence: array write while the
	// buffer is full, command write with no data, launch with no command.
	assign seq_err = (arr_wr && (!cbe_reg || seq_reg != SEQ_IDLE)) ||
		(wr_cmd && seq_reg != SEQ_DATA) ||
		(launch && seq_reg != SEQ_CMD);

	// Only a burst behind a running burst may wait in the buffer.
	always_comb begin
		launch_err = 1'b0;
		launch_ok = 1'b0;
		if (launch && seq_reg == SEQ_CMD) begin
			if (!legal) begin
				launch_err = 1'b1;
			end else if (is_modify && !div_set_reg) begin
				launch_err = 1'b1;
			end else if (busy && !(is_burst && !pend_reg &&
				run_cmd_reg == fcs_pkg::CMD_BURST_PROGRAM)) begin
				launch_err = 1'b1;
			end else if (!prot_hit) begin
				launch_ok = 1'b1;
			end
		end
	end

	assign stop_err = stop_entry && busy;
	assign transfer = pend_reg && !run_reg && !stop_entry;

	// ==========================================================
	// Sequence tracker.
	// ==========================================================
	// Any launch attempt or error ends the sequence, so an ignored
	// command never leaves stale latches armed.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_reg <= SEQ_IDLE;
		end else if (seq_err || launch || stop_entry) begin
			seq_reg <= SEQ_IDLE;
		end else if (arr_wr) begin
			seq_reg <= SEQ_DATA;
		end else if (wr_cmd) begin
			seq_reg <= SEQ_CMD;
		end
	end

	// Latch the array write and the command code.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lat_addr_reg <= '0;
			lat_data_reg <= fcs_pkg::RST_BYTE;
			lat_cmd_reg <= fcs_pkg::RST_BYTE;
		end else begin
			if (arr_wr && !seq_err) begin
				lat_addr_reg <= arr_addr;
				lat_data_reg <= arr_wdata;
			end
			if (wr_cmd && !seq_err) begin
				lat_cmd_reg <= bus_req.wdata;
			end
		end
	end

	// ==========================================================
	// Command buffer and engine handover.
	// ==========================================================
	// The buffer holds one accepted command; it empties into the
	// engine as soon as the engine is free.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg <= 1'b0;
			pend_op_reg <= '0;
		end else if (stop_entry) begin
			pend_reg <= 1'b0;
		end else if (launch_ok) begin
			pend_reg <= 1'b1;
			pend_op_reg <= '{lat_cmd_reg, lat_addr_reg, lat_data_reg};
		end else if (transfer) begin
			pend_reg <= 1'b0;
		end
	end

	// Engine occupancy; stop entry aborts the running command.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			run_reg <= 1'b0;
			run_cmd_reg <= fcs_pkg::RST_BYTE;
			op_start <= 1'b0;
			op <= '0;
			op_abort <= 1'b0;
		end else begin
			op_start <= transfer;
			op_abort <= stop_err;
			if (stop_entry) begin
				run_reg <= 1'b0;
			end else if (transfer) begin
				run_reg <= 1'b1;
				run_cmd_reg <= pend_op_reg.cmd;
				op <= pend_op_reg;
			end else if (op_done) begin
				run_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Status flags.
	// ==========================================================
	// Buffer empty clears on the launch and sets again once the command
	// leaves the buffer for the array.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cbe_reg <= 1'b1;
		end else if (launch_ok) begin
			cbe_reg <= 1'b0;
		end else if (transfer || stop_entry) begin
			cbe_reg <= 1'b1;
		end
	end

	// Complete follows the idle condition; software writes do nothing.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cc_reg <= 1'b1;
			cc_prev_reg <= 1'b1;
		end else begin
			cc_reg <= cbe_reg && !busy && !launch_ok;
			cc_prev_reg <= cc_reg;
		end
	end

	// Blank result of the finishing check; a new launch clears it.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			blank_reg <= 1'b0;
		end else if (op_done && run_reg &&
			run_cmd_reg == fcs_pkg::CMD_BLANK_CHECK) begin
			blank_reg <= op_blank;
		end else if (launch_ok) begin
			blank_reg <= 1'b0;
		end
	end

	// Violation and access error: hardware sets, software writes one.
	fcs_sticky #(
		.W(2)
	) u_err (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.set({launch && seq_reg == SEQ_CMD && legal && prot_hit &&
			!launch_err, seq_err || launch_err || stop_err}),
		.clr({wr_stat && bus_req.wdata[fcs_pkg::ST_VIOLATION],
			wr_stat && bus_req.wdata[fcs_pkg::ST_ACCESS_ERROR]}),
		.flag(err_flags)
	);

	// ==========================================================
	// Protection, divider and security state.
	// ==========================================================
	// The nonvolatile copy is caught on the first edge after reset
	// release, since an async reset may only load constants.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			load_reg <= 1'b1;
			prot_reg <= fcs_pkg::RST_BYTE;
			sec_reg <= fcs_pkg::RST_SECURITY;
		end else if (load_reg) begin
			load_reg <= 1'b0;
			prot_reg <= nonvolatile_protection_copy;
			sec_reg <= nonvolatile_security;
		end else begin
			if (op_done && run_reg && op_blank &&
				run_cmd_reg == fcs_pkg::CMD_BLANK_CHECK) begin
				sec_reg <= fcs_pkg::SECURITY_UNSECURED;
			end
			if (wr_prot && debug_active) begin
				prot_reg <= bus_req.wdata;
			end else if (wr_prot && prot_reg[fcs_pkg::PROT_DISABLE_BIT]) begin
				prot_reg <= prot_reg;
			end else if (wr_prot && !bus_req.wdata[0] &&
				bus_req.wdata[7:1] < prot_reg[7:1]) begin
				prot_reg <= bus_req.wdata;
			end
		end
	end

	// The divider value itself is only passed on; the engine times pulses.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_reg <= fcs_pkg::RST_BYTE;
			div_set_reg <= 1'b0;
		end else if (wr_div) begin
			div_reg <= bus_req.wdata;
			div_set_reg <= 1'b1;
		end
	end

	assign flash_clock_divider = div_reg;
	assign security_code = sec_reg;

	// ==========================================================
	// Interrupts.
	// ==========================================================
	// Events: completion edge, new violation, new access error.
	fcs_sticky #(
		.W(IRQ_W_L)
	) u_irq (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.set({seq_err || launch_err || stop_err,
			launch && seq_reg == SEQ_CMD && legal && prot_hit && !launch_err,
			cc_reg && !cc_prev_reg}),
		.clr(wr_irqs ? bus_req.wdata[IRQ_W_L-1:0] : {IRQ_W_L{1'b0}}),
		.flag(irq_flags)
	);

	// Mask register, a one lets the matching status bit through.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask_reg <= '0;
		end else if (wr_mask) begin
			irq_mask_reg <= bus_req.wdata[IRQ_W_L-1:0];
		end
	end

	// Level output held while any unmasked bit stands.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_flags & irq_mask_reg);
		end
	end

	// ==========================================================
	// Read port.
	// ==========================================================
	// Status image; bits without a function stay zero.
	always_comb begin
		stat_byte = fcs_pkg::RST_BYTE;
		stat_byte[fcs_pkg::ST_BUFFER_EMPTY] = cbe_reg;
		stat_byte[fcs_pkg::ST_COMPLETE] = cc_reg;
		stat_byte[fcs_pkg::ST_VIOLATION] = err_flags[1];
		stat_byte[fcs_pkg::ST_ACCESS_ERROR] = err_flags[0];
		stat_byte[fcs_pkg::ST_BLANK] = blank_reg;
	end

	// Read data stands in the cycle after the strobe and only then.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= fcs_pkg::RST_BYTE;
		end else if (!bus_req.rd) begin
			rd_data <= fcs_pkg::RST_BYTE;
		end else begin
			unique case (bus_req.addr)
				fcs_pkg::OFS_PROTECTION: rd_data <= prot_reg;
				fcs_pkg::OFS_STATUS: rd_data <= stat_byte;
				fcs_pkg::OFS_DIVIDER: rd_data <= div_reg;
				fcs_pkg::OFS_IRQ_STATUS: rd_data <= {5'h00, irq_flags};
				fcs_pkg::OFS_IRQ_MASK: rd_data <= {5'h00, irq_mask_reg};
				fcs_pkg::OFS_SECURITY: rd_data <= {6'h00, sec_reg};
				default: rd_data <= fcs_pkg::RST_BYTE;
			endcase
		end
	end

endmodule // fcs_flash_cmd

// file: logic/fcs_pkg.sv
// Purpose: Shared constants and carriers for the flash command block.
// Assumes: Byte-wide registers on a plain strobe port, one clock.
// Notes: Every offset, bit position and code, and the byte and security reset values, live here.

package fcs_pkg;

	// ==========================================================
	// Register offsets on the plain register port.
	// ==========================================================
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_PROTECTION = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h1;
	localparam logic [3:0] OFS_COMMAND = 4'h2;
	localparam logic [3:0] OFS_DIVIDER = 4'h3;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h5;
	localparam logic [3:0] OFS_SECURITY = 4'h6;

	// ==========================================================
	// Field positions.
	// ==========================================================
	localparam int PROT_DISABLE_BIT = 0;
	localparam int PROT_SELECT_LSB = 1;
	localparam int PROT_SELECT_W = 7;
	localparam int ST_BUFFER_EMPTY = 7;
	localparam int ST_COMPLETE = 6;
	localparam int ST_VIOLATION = 5;
	localparam int ST_ACCESS_ERROR = 4;
	localparam int ST_BLANK = 2;
	// Interrupt status and mask bits.
	localparam int IRQ_W = 3;
	localparam int IRQ_COMPLETE = 0;
	localparam int IRQ_VIOLATION = 1;
	localparam int IRQ_ACCESS_ERROR = 2;
	// Page erase granularity is 512 bytes, so nine offset bits.
	localparam int PAGE_BITS = 9;

	// ==========================================================
	// Command codes and security values.
	// ==========================================================
	localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
	localparam logic [7:0] CMD_BYTE_PROGRAM = 8'h20;
	localparam logic [7:0] CMD_BURST_PROGRAM = 8'h25;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
	localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
	localparam logic [1:0] SECURITY_UNSECURED = 2'h2;

	// ==========================================================
	// Reset values.
	// ==========================================================
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [1:0] RST_SECURITY = 2'h0;

	// Register port request, one strobe at a time.
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} fcs_bus_req_t;

	// Operation handed to the array engine.
	typedef struct packed {
		logic [7:0] cmd;
		logic [15:0] addr;
		logic [7:0] data;
	} fcs_op_t;

endpackage

// file: logic/fcs_sticky.sv
// Purpose: A vector of sticky flags, set by hardware, cleared by software.
// Assumes: Set and clear are single-cycle pulses on the same clock.
// Notes: A set in the same cycle as its clear wins, so no event is lost.

`timescale 1ns/1ns

module fcs_sticky #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] flag
);

	// ==========================================================
	// Flag storage.
	// ==========================================================
	// Set takes priority over clear bit by bit.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			flag <= '0;
		end else begin
			flag <= set | (flag & ~clr);
		end
	end

endmodule // fcs_sticky

// file: sim/fcs_engine_model.sv
// Purpose: Behavioural array engine that answers op_start with op_done.
// Assumes: One clock; slow selects a long run so bursts can queue.
// Notes: op_blank toggles outside op_done so nothing relies on it there.

`timescale 1ns/1ns

module fcs_engine_model (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic op_start,
	input wire logic op_abort,
	input wire logic slow,
	input wire logic blank,
	output logic op_done,
	output logic op_blank
);
	// Cycles left in the running operation, zero when idle.
	logic [4:0] cnt_reg;

	// ==========================================================
	// Engine run counter.
	// ==========================================================
	// An abort drops the run at once, as a real engine would on stop.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= 5'h00;
			op_done <= 1'b0;
			op_blank <= 1'b0;
		end else begin
			op_done <= (cnt_reg == 5'd1);
			op_blank <= (cnt_reg == 5'd1) ? blank : ~op_blank;
			if (op_abort) begin
				cnt_reg <= 5'h00;
			end else if (op_start) begin
				cnt_reg <= slow ? 5'd20 : 5'd2;
			end else if (cnt_reg != 5'h00) begin
				cnt_reg <= cnt_reg - 5'd1;
			end
		end
	end
endmodule // fcs_engine_model

// file: sim/fcs_flash_cmd_sva.sv
// Purpose: Port-level assertions for the flash command block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Bound to every instance of fcs_flash_cmd.

`timescale 1ns/1ns

module fcs_flash_cmd_sva (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire fcs_pkg::fcs_bus_req_t bus_req,
	input wire logic [7:0] rd_data,
	input wire logic stop_entry,
	input wire logic op_start,
	input wire fcs_pkg::fcs_op_t op,
	input wire logic op_abort,
	input wire logic op_done,
	input wire logic op_blank,
	input wire logic [1:0] security_code
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	// Shift register that hides the load edge after each reset release.
	logic [1:0] up_reg;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			up_reg <= 2'b00;
		end else begin
			up_reg <= {up_reg[0], 1'b1};
		end
	end

	// ==========================================================
	// Named steps.
	// ==========================================================
	sequence s_read(logic [3:0] ad);
		bus_req.rd && bus_req.addr == ad;
	endsequence
	sequence s_blank_pass;
		op_done && op_blank && op.cmd == fcs_pkg::CMD_BLANK_CHECK;
	endsequence

	a_rd_idle_zero: assert property (!bus_req.rd |=> rd_data == 8'h00)
		else $error("read data not zero outside read answer");
	a_status_spare: assert property (s_read(fcs_pkg::OFS_STATUS) |=>
		rd_data[3] == 1'b0 && rd_data[1:0] == 2'b00)
		else $error("undefined status bits read nonzero");
	a_cmd_write_only: assert property (s_read(fcs_pkg::OFS_COMMAND) |=>
		rd_data == 8'h00) else $error("command register read nonzero");
	a_blank_unsecure: assert property (s_blank_pass |=>
		security_code == fcs_pkg::SECURITY_UNSECURED)
		else $error("passing blank check left device secured");
	a_sec_only_blank: assert property (up_reg[1] && $changed(security_code)
		|-> $past(op_done && op_blank)) else $error("security changed alone");
	a_start_single: assert property (op_start |=> !op_start)
		else $error("engine start longer than one cycle");
	a_op_held: assert property (!op_start |-> $stable(op))
		else $error("operation changed without a start");
	a_start_legal: assert property (op_start |-> op.cmd inside {
		8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("illegal code started");
	a_abort_after_stop: assert property (op_abort |-> $past(stop_entry))
		else $error("abort without stop entry");
endmodule // fcs_flash_cmd_sva

bind fcs_flash_cmd fcs_flash_cmd_sva u_sva (.ref_clk(ref_clk), .arst_n(arst_n),
	.bus_req(bus_req), .rd_data(rd_data), .stop_entry(stop_entry),
	.op_start(op_start), .op(op), .op_abort(op_abort), .op_done(op_done),
	.op_blank(op_blank), .security_code(security_code));

// file: sim/test_fcs_flash_cmd.sv
// Purpose: Self-checking bench for the flash command block.
// Assumes: Engine model answers starts; bench acts as the CPU.
// Notes: Random addresses and illegal codes from seed 13.

`timescale 1ns/1ns

module test_fcs_flash_cmd;
	logic ref_clk, arst_n, dbg, stop, arr_wr, op_start, op_abort, op_done;
	logic op_blank, irq, slow;
	fcs_pkg::fcs_bus_req_t bus_req;
	fcs_pkg::fcs_op_t op, last_op;
	logic [7:0] nv_prot, rd_data, divider, d, code, arr_wdata;
	logic [1:0] sec;
	logic [15:0] arr_addr, a;
	int miscompares, samples_checked, starts, seed, i, n;
	logic [7:0] codes [4] = '{8'h05, 8'h20, 8'h40, 8'h25};

	fcs_flash_cmd u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .bus_req(bus_req),
		.rd_data(rd_data), .nonvolatile_protection_copy(nv_prot),
		.nonvolatile_security(2'b00), .debug_active(dbg), .stop_entry(stop),
		.arr_wr(arr_wr), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
		.op_start(op_start), .op(op), .op_abort(op_abort), .op_done(op_done),
		.op_blank(op_blank), .flash_clock_divider(divider),
		.security_code(sec), .irq(irq));
	fcs_engine_model u_eng (.ref_clk(ref_clk), .arst_n(arst_n),
		.op_start(op_start), .op_abort(op_abort), .slow(slow), .blank(1'b1),
		.op_done(op_done), .op_blank(op_blank));

	// ==========================================================
	// Clock, start counter and watchdog.
	// ==========================================================
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (op_start === 1'b1) begin
			starts++;
			last_op <= op;
		end
	end
	initial begin
		#160000;
		miscompares++;
		stop_test();
	end

	// ==========================================================
	// Shared tasks.
	// ==========================================================
	task check(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [3:0] ad, input logic [7:0] dt);
		@(posedge ref_clk);
		bus_req <= '{1'b1, 1'b0, ad, dt};
		@(posedge ref_clk);
		bus_req <= '0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task rd(input logic [3:0] ad);
		@(posedge ref_clk);
		bus_req <= '{1'b0, 1'b1, ad, 8'h00};
		@(posedge ref_clk);
		bus_req <= '0;
		@(negedge ref_clk);
		d = rd_data;
	endtask
	task launch(input logic [15:0] ad, input logic [7:0] cd);
		@(posedge ref_clk);
		arr_wr <= 1'b1;
		arr_addr <= ad;
		arr_wdata <= ad[7:0];
		@(posedge ref_clk);
		arr_wr <= 1'b0;
		wr(fcs_pkg::OFS_COMMAND, cd);
		wr(fcs_pkg::OFS_STATUS, 8'h80);
	endtask
	// Bounded poll until the complete flag comes back.
	task wait_done();
		for (int k = 0; k < 80; k++) begin
			rd(fcs_pkg::OFS_STATUS);
			if (d[6] === 1'b1) break;
		end
	endtask
	task set_dbg(input logic v);
		@(posedge ref_clk);
		dbg <= v;
	endtask
	task stop_test();
		$display("checks=%0d mismatches=%0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence.
	// ==========================================================
	initial begin
		seed = 13;
		arst_n = 1'b0;
		bus_req = '0;
		{dbg, stop, arr_wr, slow} = 4'h0;
		arr_addr = 16'h0000;
		arr_wdata = 8'h00;
		nv_prot = 8'h80;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rd(fcs_pkg::OFS_PROTECTION); check(d, 8'h80);
		rd(fcs_pkg::OFS_STATUS); check(d, 8'hC0);
		wr(fcs_pkg::OFS_PROTECTION, 8'h60);
		rd(fcs_pkg::OFS_PROTECTION); check(d, 8'h60);
		wr(fcs_pkg::OFS_PROTECTION, 8'h70);
		rd(fcs_pkg::OFS_PROTECTION); check(d, 8'h60);
		set_dbg(1'b1);
		wr(fcs_pkg::OFS_PROTECTION, 8'hFF);
		set_dbg(1'b0);
		rd(fcs_pkg::OFS_PROTECTION); check(d, 8'hFF);
		wr(fcs_pkg::OFS_PROTECTION, 8'h00);
		rd(fcs_pkg::OFS_PROTECTION); check(d, 8'hFF);
		set_dbg(1'b1);
		wr(fcs_pkg::OFS_PROTECTION, 8'h60);
		set_dbg(1'b0);
		// Program before the divider is written must be refused.
		launch(16'h0010, fcs_pkg::CMD_BYTE_PROGRAM);
		rd(fcs_pkg::OFS_STATUS); check(d[4], 1'b1);
		wr(fcs_pkg::OFS_STATUS, 8'h00);
		rd(fcs_pkg::OFS_STATUS); check(d[4], 1'b1);
		wr(fcs_pkg::OFS_STATUS, 8'h10);
		rd(fcs_pkg::OFS_STATUS); check(d[4], 1'b0);
		wr(fcs_pkg::OFS_DIVIDER, 8'h13);
		wr(fcs_pkg::OFS_IRQ_MASK, 8'h01);
		check(divider, 8'h13);
		for (i = 0; i < 4; i++) begin
			a = 16'($random(seed)) & 16'h3FFF;
			launch(a, codes[i]);
			rd(fcs_pkg::OFS_STATUS); check(d[6], 1'b0);
			wait_done();
			check(last_op.cmd, codes[i]);
			check(starts, i + 1);
			check(d[2], codes[i] == fcs_pkg::CMD_BLANK_CHECK);
		end
		check(sec, 2'b10);
		check(irq, 1'b1);
		wr(fcs_pkg::OFS_IRQ_STATUS, 8'h01);
		rd(fcs_pkg::OFS_IRQ_STATUS); check(d[0], 1'b0);
		check(irq, 1'b0);
		// Protected top of array and mass erase are both refused.
		launch(16'hFF00, fcs_pkg::CMD_BYTE_PROGRAM);
		rd(fcs_pkg::OFS_STATUS); check(d[5], 1'b1);
		wr(fcs_pkg::OFS_STATUS, 8'h20);
		rd(fcs_pkg::OFS_STATUS); check(d[5], 1'b0);
		launch(16'h0000, fcs_pkg::CMD_MASS_ERASE);
		rd(fcs_pkg::OFS_STATUS); check(d[5], 1'b1);
		check(starts, 4);
		wr(fcs_pkg::OFS_STATUS, 8'h20);
		set_dbg(1'b1);
		wr(fcs_pkg::OFS_PROTECTION, 8'h61);
		set_dbg(1'b0);
		launch(16'hFF00, fcs_pkg::CMD_MASS_ERASE);
		// No blank check follows the mass erase before further commands.
		wait_done(); check(starts, 5);
		for (i = 0; i < 4; i++) begin
			code = 8'($random(seed));
			if (code inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) code = 8'h77;
			launch(16'h0010, code);
			rd(fcs_pkg::OFS_STATUS); check(d[4], 1'b1);
			wr(fcs_pkg::OFS_STATUS, 8'h10);
		end
		// Two bursts queue behind a slow engine; a byte program may not.
		slow = 1'b1;
		n = starts;
		launch(16'h0020, fcs_pkg::CMD_BURST_PROGRAM);
		launch(16'h0021, fcs_pkg::CMD_BURST_PROGRAM);
		rd(fcs_pkg::OFS_STATUS); check(d[4], 1'b0);
		launch(16'h0022, fcs_pkg::CMD_BYTE_PROGRAM);
		rd(fcs_pkg::OFS_STATUS); check(d[4], 1'b1);
		wait_done(); check(starts, n + 2);
		wr(fcs_pkg::OFS_STATUS, 8'h10);
		launch(16'h0030, fcs_pkg::CMD_BYTE_PROGRAM);
		@(posedge ref_clk);
		stop <= 1'b1;
		@(posedge ref_clk);
		stop <= 1'b0;
		rd(fcs_pkg::OFS_STATUS); check(d[4], 1'b1);
		check(d[7], 1'b1);
		wr(4'hF, 8'hAA);
		rd(4'hF); check(d, 8'h00);
		rd(fcs_pkg::OFS_COMMAND); check(d, 8'h00);
		// Second reset reloads a new protection copy.
		@(posedge ref_clk);
		arst_n <= 1'b0;
		nv_prot <= 8'h41;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rd(fcs_pkg::OFS_PROTECTION); check(d, 8'h41);
		rd(fcs_pkg::OFS_STATUS); check(d, 8'hC0);
		stop_test();
	end
endmodule // test_fcs_flash_cmd
